// [rtl/fcm_pkg.sv]
// Package for the flash controller mux and interrupt map glue.
// Assumes a single system clock and a synchronous active-high reset.
package fcm_pkg;

  // Interrupt line numbers
  localparam int IRQ_WIDTH = 32;
  localparam int SERIAL_PORT_IRQ_LINE = 0;
  localparam int FIRST_IO_PORT_IRQ_LINE = 1;
  localparam int SECOND_IO_PORT_IRQ_LINE = 2;
  localparam int BASE_FLASH_CTRL_IRQ_LINE = 3;
  localparam int ADAPTOR_PROG_FLASH_IRQ_LINE = 4;
  localparam int ADAPTOR_SINGLE_SERIAL_IRQ_LINE = 5;
  localparam int ADAPTOR_EXEC_FLASH_IRQ_LINE = 6;
  localparam int ADAPTOR_FITTED_LINE = 31;

  // Select bit position within the first adaptor output port
  localparam int SELECT_BIT = 0;
  localparam int IO_PORT_WIDTH = 32;

  // Boot address of the execute-in-place controller
  localparam logic [31:0] EXEC_BOOT_ADDR = 32'h0000_0000;

  // Controller choice; reset value is execute-in-place
  typedef enum logic [0:0] {
    FCM_SEL_EXEC = 1'b0,
    FCM_SEL_PROG = 1'b1
  } fcm_sel_t;
  localparam fcm_sel_t SEL_RESET = FCM_SEL_EXEC;

  // Reset and idle values
  localparam logic [3:0] DQ_IDLE = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic FITTED_N_RESET = 1'b1;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 32'h8000_0000;

  // Quad-SPI pin group, one side of the mux
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
  } fcm_qspi_drv_t;

  localparam fcm_qspi_drv_t QSPI_IDLE = '{sclk: 1'b0, cs_n: 1'b1, dq_o: 4'h0, dq_oe: 4'h0};

  // Peripheral interrupt sources
  typedef struct packed {
    logic serial_port;
    logic first_io_port;
    logic second_io_port;
    logic base_flash_ctrl;
    logic adaptor_prog_flash;
    logic adaptor_single_serial;
    logic adaptor_exec_flash;
  } fcm_irq_src_t;

endpackage

// [rtl/fcm_sync.sv]
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level; output lags by two edges.
`timescale 1ns/100ps
module fcm_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_val,
  // Level
  input wire logic d,
  output logic q
);
  logic stage;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage <= rst_val;
      q <= rst_val;
    end
    else
    begin
      stage <= d;
      q <= stage;
    end
  end
endmodule

// [rtl/fcm_top.sv]
// Flash controller mux and processor interrupt line map.
// Assumes peripheral interrupts and the select come from CLK-domain logic;
// the adaptor-fitted strap is a board pin and is synchronised.
// The select reaches the pins two edges after the port bit changes;
// flash read data reaches the owning controller three edges after the pins.
`timescale 1ns/100ps
module fcm_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Adaptor output port and fitted strap
  input wire logic [fcm_pkg::IO_PORT_WIDTH-1:0] ADAPTOR_IO_OUT,
  input wire logic ADAPTOR_FITTED_N,
  // Controller drives
  input wire fcm_pkg::fcm_qspi_drv_t EXEC_QSPI,
  input wire fcm_pkg::fcm_qspi_drv_t PROG_QSPI,
  // Flash pins
  input wire logic [3:0] FLASH_DQ_IN,
  output logic FLASH_SCLK,
  output logic FLASH_CS_N,
  output logic [3:0] FLASH_DQ_OUT,
  output logic [3:0] FLASH_DQ_OE,
  // Read data back to the controllers
  output logic [3:0] EXEC_DQ_IN,
  output logic [3:0] PROG_DQ_IN,
  // Interrupts
  input wire fcm_pkg::fcm_irq_src_t IRQ_SRC,
  output logic [fcm_pkg::IRQ_WIDTH-1:0] PROC_IRQ,
  // Status
  output logic FLASH_SEL_PROG,
  output logic EXEC_AT_ZERO,
  output logic FETCH_HAZARD
);
  fcm_pkg::fcm_sel_t sel;
  fcm_pkg::fcm_sel_t next_sel;
  fcm_pkg::fcm_qspi_drv_t next_drv;
  logic fitted_n_sync;
  logic [3:0] dq_meta;
  logic [3:0] dq_sync;
  logic [fcm_pkg::IRQ_WIDTH-1:0] next_irq;

  // Normal-mode controller owns the flash
  function automatic logic sel_is_prog(input fcm_pkg::fcm_sel_t s);
    return s == fcm_pkg::FCM_SEL_PROG;
  endfunction

  // Adaptor strap is active low
  function automatic logic adaptor_fitted(input logic fitted_n);
    return !fitted_n;
  endfunction

  // Adaptor strap, taken through two flops; reads as not fitted in reset
  fcm_sync u_fitted_sync (
    .clk(CLK),
    .rst(RST),
    .rst_val(fcm_pkg::FITTED_N_RESET),
    .d(ADAPTOR_FITTED_N),
    .q(fitted_n_sync)
  );

  // Select line from port bit 0
  always_comb
  begin
    if (ADAPTOR_IO_OUT[fcm_pkg::SELECT_BIT])
      next_sel = fcm_pkg::FCM_SEL_PROG;
    else
      next_sel = fcm_pkg::FCM_SEL_EXEC;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      sel <= fcm_pkg::SEL_RESET;
    else
      sel <= next_sel;
  end

  // Only one controller reaches the pins
  always_comb
  begin
    unique case (sel)
      fcm_pkg::FCM_SEL_EXEC: next_drv = EXEC_QSPI;
      fcm_pkg::FCM_SEL_PROG: next_drv = PROG_QSPI;
    endcase
  end

  // Serial clock from the owning controller
  always_ff @(posedge CLK)
  begin
    if (RST)
      FLASH_SCLK <= fcm_pkg::QSPI_IDLE.sclk;
    else
      FLASH_SCLK <= next_drv.sclk;
  end

  // Chip select from the owning controller
  always_ff @(posedge CLK)
  begin
    if (RST)
      FLASH_CS_N <= fcm_pkg::QSPI_IDLE.cs_n;
    else
      FLASH_CS_N <= next_drv.cs_n;
  end

  // Data out from the owning controller
  always_ff @(posedge CLK)
  begin
    if (RST)
      FLASH_DQ_OUT <= fcm_pkg::QSPI_IDLE.dq_o;
    else
      FLASH_DQ_OUT <= next_drv.dq_o;
  end

  // Data enables from the owning controller; high drives the pin
  always_ff @(posedge CLK)
  begin
    if (RST)
      FLASH_DQ_OE <= fcm_pkg::QSPI_IDLE.dq_oe;
    else
      FLASH_DQ_OE <= next_drv.dq_oe;
  end

  // Flash read data through two flops
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dq_meta <= fcm_pkg::DQ_IDLE;
      dq_sync <= fcm_pkg::DQ_IDLE;
    end
    else
    begin
      dq_meta <= FLASH_DQ_IN;
      dq_sync <= dq_meta;
    end
  end

  // Unselected controller sees idle data, so fetches fail when deselected
  always_ff @(posedge CLK)
  begin
    if (RST)
      EXEC_DQ_IN <= fcm_pkg::DQ_IDLE;
    else if (sel_is_prog(sel))
      EXEC_DQ_IN <= fcm_pkg::DQ_IDLE;
    else
      EXEC_DQ_IN <= dq_sync;
  end

  // Normal-mode controller sees data only while selected
  always_ff @(posedge CLK)
  begin
    if (RST)
      PROG_DQ_IN <= fcm_pkg::DQ_IDLE;
    else if (sel_is_prog(sel))
      PROG_DQ_IN <= dq_sync;
    else
      PROG_DQ_IN <= fcm_pkg::DQ_IDLE;
  end

  // Interrupt line map
  always_comb
  begin
    next_irq = '0;
    next_irq[fcm_pkg::SERIAL_PORT_IRQ_LINE] = IRQ_SRC.serial_port;
    next_irq[fcm_pkg::FIRST_IO_PORT_IRQ_LINE] = IRQ_SRC.first_io_port;
    next_irq[fcm_pkg::SECOND_IO_PORT_IRQ_LINE] = IRQ_SRC.second_io_port;
    next_irq[fcm_pkg::BASE_FLASH_CTRL_IRQ_LINE] = IRQ_SRC.base_flash_ctrl;
    next_irq[fcm_pkg::ADAPTOR_PROG_FLASH_IRQ_LINE] = IRQ_SRC.adaptor_prog_flash;
    next_irq[fcm_pkg::ADAPTOR_SINGLE_SERIAL_IRQ_LINE] = IRQ_SRC.adaptor_single_serial;
    next_irq[fcm_pkg::ADAPTOR_EXEC_FLASH_IRQ_LINE] = IRQ_SRC.adaptor_exec_flash;
    next_irq[fcm_pkg::ADAPTOR_FITTED_LINE] = fitted_n_sync;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      PROC_IRQ <= fcm_pkg::IRQ_RESET;
    else
      PROC_IRQ <= next_irq;
  end

  // Normal-mode controller selected
  always_ff @(posedge CLK)
  begin
    if (RST)
      FLASH_SEL_PROG <= fcm_pkg::FLAG_RESET;
    else
      FLASH_SEL_PROG <= sel_is_prog(sel);
  end

  // Address decode moves the exec controller to zero when fitted
  always_ff @(posedge CLK)
  begin
    if (RST)
      EXEC_AT_ZERO <= fcm_pkg::FLAG_RESET;
    else
      EXEC_AT_ZERO <= adaptor_fitted(fitted_n_sync);
  end

  // Booting from flash with the normal controller selected: fetches stall
  always_ff @(posedge CLK)
  begin
    if (RST)
      FETCH_HAZARD <= fcm_pkg::FLAG_RESET;
    else if (adaptor_fitted(fitted_n_sync))
      FETCH_HAZARD <= sel_is_prog(sel);
    else
      FETCH_HAZARD <= fcm_pkg::FLAG_RESET;
  end
endmodule

// [test/fcm_top_properties.sv]
// Checker for the flash mux and interrupt map.
// Sees fcm_top ports only; bound below.
`timescale 1ns/100ps
module fcm_chk (
  // Watched ports
  input wire logic CLK,
  input wire logic RST,
  input wire logic [31:0] ADAPTOR_IO_OUT,
  input wire logic ADAPTOR_FITTED_N,
  input wire fcm_pkg::fcm_irq_src_t IRQ_SRC,
  input wire logic [31:0] PROC_IRQ,
  input wire logic FLASH_SEL_PROG,
  input wire logic EXEC_AT_ZERO,
  input wire logic FETCH_HAZARD
);
  logic [1:0] age;
  always_ff @(posedge CLK) age <= RST ? 2'h0 : age + {1'b0, ~&age};
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_sel; age[1] |-> FLASH_SEL_PROG == $past(ADAPTOR_IO_OUT[0], 2); endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_io; |age |-> PROC_IRQ[2:0] == $past({IRQ_SRC[4], IRQ_SRC[5], IRQ_SRC[6]}); endproperty
  a_io: assert property (p_io) else $error("irq 0-2 wrong");
  property p_base; |age |-> PROC_IRQ[3] == $past(IRQ_SRC[3]); endproperty
  a_base: assert property (p_base) else $error("irq 3 wrong");
  property p_adp; |age |-> PROC_IRQ[6:4] == $past({IRQ_SRC[0], IRQ_SRC[1], IRQ_SRC[2]}); endproperty
  a_adp: assert property (p_adp) else $error("irq 4-6 wrong");
  property p_fit; &age |-> PROC_IRQ[31] == $past(ADAPTOR_FITTED_N, 3); endproperty
  a_fit: assert property (p_fit) else $error("irq 31 wrong");
  property p_zero; &age |-> EXEC_AT_ZERO == !$past(ADAPTOR_FITTED_N, 3); endproperty
  a_zero: assert property (p_zero) else $error("boot decode wrong");
  property p_haz; &age |-> FETCH_HAZARD == (FLASH_SEL_PROG && EXEC_AT_ZERO); endproperty
  a_haz: assert property (p_haz) else $error("hazard wrong");
  property p_rst; disable iff (1'b0) RST |=> !FLASH_SEL_PROG && PROC_IRQ == 32'h8000_0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind fcm_top fcm_chk u_chk (.CLK(CLK), .RST(RST), .ADAPTOR_IO_OUT(ADAPTOR_IO_OUT),
  .ADAPTOR_FITTED_N(ADAPTOR_FITTED_N), .IRQ_SRC(IRQ_SRC), .PROC_IRQ(PROC_IRQ),
  .FLASH_SEL_PROG(FLASH_SEL_PROG), .EXEC_AT_ZERO(EXEC_AT_ZERO), .FETCH_HAZARD(FETCH_HAZARD));

// [test/fcm_flash_model.sv]
// Flash device model on the far side of the mux.
// Fixed nibble while selected; changes every cycle when deselected.
`timescale 1ns/100ps
module fcm_flash_model (
  // Pins
  input wire logic clk,
  input wire logic cs_n,
  output logic [3:0] dq
);
  initial dq = 4'h5;
  always @(posedge clk) dq <= cs_n ? ~dq : 4'hA;
endmodule

// [test/tb_top.sv]
// Bench for the flash mux and interrupt map.
// Assumes the checker and flash model are compiled first.
`timescale 1ns/100ps
module tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic fit_n = 1'b1;
  logic [31:0] io = 32'h0;
  fcm_pkg::fcm_qspi_drv_t exq = fcm_pkg::QSPI_IDLE;
  fcm_pkg::fcm_qspi_drv_t pgq = fcm_pkg::QSPI_IDLE;
  fcm_pkg::fcm_irq_src_t src = '0;
  logic [31:0] irq;
  logic [3:0] dq, dqo, oe, exd, pgd;
  logic sck, csn, selp, atz, haz;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 CLK = ~CLK;
  fcm_top dut (.CLK(CLK), .RST(RST), .ADAPTOR_IO_OUT(io), .ADAPTOR_FITTED_N(fit_n),
    .EXEC_QSPI(exq), .PROG_QSPI(pgq), .FLASH_DQ_IN(dq), .FLASH_SCLK(sck), .FLASH_CS_N(csn),
    .FLASH_DQ_OUT(dqo), .FLASH_DQ_OE(oe), .EXEC_DQ_IN(exd), .PROG_DQ_IN(pgd), .IRQ_SRC(src),
    .PROC_IRQ(irq), .FLASH_SEL_PROG(selp), .EXEC_AT_ZERO(atz), .FETCH_HAZARD(haz));
  fcm_flash_model mem (.clk(CLK), .cs_n(csn), .dq(dq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    n_errors += int'(got !== exp);
    if (got !== exp)
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_irq;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge CLK) src <= 7'h40 >> i;
      tick(2);
      chk(irq, 32'h8000_0000 | 32'h1 << i);
    end
    $display("t_irq done");
  endtask
  task automatic t_mux;
    @(posedge CLK)
    begin
      exq <= 10'h23F;
      pgq <= 10'h0C5;
      io <= 32'hFFFF_FFFE;
    end
    tick(6);
    chk({selp, sck, csn, dqo, oe, exd, pgd}, 19'h23FA0);
    @(posedge CLK) io <= 32'h1;
    tick(6);
    chk({selp, sck, csn, dqo, oe, exd, pgd}, 19'h4C50A);
    $display("t_mux done");
  endtask
  task automatic t_fit;
    @(posedge CLK) fit_n <= 1'b0;
    tick(4);
    chk({irq[31], atz, haz}, 3'h3);
    @(posedge CLK) RST <= 1'b1;
    tick(1);
    chk({selp, csn, irq[31]}, 3'h3);
    @(posedge CLK) RST <= 1'b0;
    tick(5);
    chk({selp, irq[31], haz}, 3'h5);
    @(posedge CLK) io <= 32'h0;
    tick(3);
    chk({selp, haz}, 2'h0);
    $display("t_fit done");
  endtask
  always @(posedge CLK)
    if (++cyc == 2000)
    begin
      n_errors++;
      test_done;
    end
  initial
  begin
    tick(3);
    @(posedge CLK) RST <= 1'b0;
    tick(3);
    chk(irq, 32'h8000_0000);
    t_irq;
    t_mux;
    t_fit;
    test_done;
  end
endmodule
